// File: inc/rrcf_defs.vh
// Purpose: Constants for the redundant reference clock failover block
// Assumes: Core clock 125 MHz, register port with one-cycle read latency
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef RRCF_DEFS_VH
`define RRCF_DEFS_VH
`define RRCF_OFS_CTRL     8'h00
`define RRCF_OFS_STATUS   8'h04
`define RRCF_OFS_IRQ_STAT 8'h08
`define RRCF_OFS_IRQ_MASK 8'h0c
`define RRCF_OFS_WINDOW   8'h10
`define RRCF_BIT_FAIL0    0
`define RRCF_BIT_FAIL1    1
`define RRCF_BIT_SWITCH   2
`define RRCF_IRQ_W        3
`define RRCF_MASK_RST     3'h0
// Longest reference period watched: 1/15 MHz = 66.667 ns
`define RRCF_REF_PERIOD_PS 66667
`define RRCF_CLK_PERIOD_PS 8000
// Least time, rounded up to whole core cycles
`define RRCF_WINDOW_CYC ((`RRCF_REF_PERIOD_PS + `RRCF_CLK_PERIOD_PS - 1) / `RRCF_CLK_PERIOD_PS)
`endif

// File: src/rrcf_edge_sync.v
// Purpose: Synchronise a pin and detect its falling edge
// Assumes: Pin idles high
// Notes:   First flop feeds only the second
`timescale 1ns/10ps
module rrcf_edge_sync (
    input  wire clk,                          // Core clock
    input  wire srst,                         // Synchronous reset
    input  wire pin_n,                        // Asynchronous active-low pin
    output wire fall                          // One-cycle fall event
);
    reg s1;                                   // First stage
    reg s2;                                   // Second stage
    reg s3;                                   // Edge history

    // Two-flop synchroniser plus history; resets to idle-high
    always @(posedge clk)
    begin
        if (srst)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end
        else
        begin
            s1 <= pin_n;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Only the transition counts, holding low gives no repeat
    assign fall = s3 & ~s2;
endmodule // rrcf_edge_sync

// File: src/rrcf_stuck_mon.v
// Purpose: Stuck-high / stuck-low monitor for one reference input
// Assumes: Reference sampled as synchronous to clk
// Notes:   Counts core cycles without a level change
`timescale 1ns/10ps
module rrcf_stuck_mon #(
    parameter CW = 8                          // Counter width
) (
    input  wire          clk,                 // Core clock
    input  wire          srst,                // Synchronous reset
    input  wire          ref_in,              // Reference input
    input  wire [CW-1:0] window,              // Cycles counted as one period
    output reg           stuck                // One-cycle failure pulse
);
    reg          ref_q;                       // Previous reference level
    reg [CW-1:0] run;                         // Cycles since last change

    // Independent timebase: runs on core clock, reset by reference edges
    always @(posedge clk)
    begin
        if (srst)
        begin
            ref_q <= 1'b0;
            run   <= {CW{1'b0}};
            stuck <= 1'b0;
        end
        else
        begin
            ref_q <= ref_in;
            stuck <= 1'b0;
            if (ref_in != ref_q)              // Edge seen, restart
                run <= {CW{1'b0}};
            else if (run != window)
                run <= run + {{(CW-1){1'b0}}, 1'b1};
            if (ref_in == ref_q && run + {{(CW-1){1'b0}}, 1'b1} == window)
                stuck <= 1'b1;
        end
    end
endmodule // rrcf_stuck_mon

// File: src/rrcf_top.v
// Purpose: Reference selection, failure alarms and failover control
// Assumes: All inputs but the clear pin synchronous to clk
// Notes:   Register port exposes state, mask, interrupts
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "rrcf_defs.vh"
module rrcf_top #(
    parameter NOUT = 6,                       // Outputs per bank
    parameter CW   = 8                        // Stuck counter width
) (
    input  wire            clk,               // Core clock
    input  wire            srst,              // Synchronous reset
    input  wire            ref_input_zero,    // Reference input 0
    input  wire            ref_input_one,     // Reference input 1
    input  wire            primary_select,    // High: input 1 primary
    input  wire            manual_auto_n,     // Low manual, high auto
    input  wire            fail_flag_clear_n, // Falling edge clears alarms
    input  wire            output_disable_master_reset, // High: reset, tri-state
    input  wire [NOUT-1:0] bank_a_drive,      // Bank A source levels
    input  wire [NOUT-1:0] bank_b_drive,      // Bank B source levels
    output wire            ref_clk_out,       // Selected loop reference
    output reg             active_ref_indicator, // Low 0, high 1
    output reg             fail_flag_0_n,     // Alarm input 0, active low
    output reg             fail_flag_1_n,     // Alarm input 1, active low
    output wire            auto_failover_mode,// Automatic mode active
    output wire            divider_reset,     // Holds dividers in reset
    output reg  [NOUT-1:0] bank_a_outputs,    // Bank A data
    output wire [NOUT-1:0] bank_a_oe,         // Bank A drive enables
    output reg  [NOUT-1:0] bank_b_outputs,    // Bank B data
    output wire [NOUT-1:0] bank_b_oe,         // Bank B drive enables
    input  wire [7:0]      reg_addr,          // Register byte address
    input  wire [31:0]     reg_wdata,         // Write data
    input  wire            reg_wr,            // Write strobe
    input  wire            reg_rd,            // Read strobe
    output reg  [31:0]     reg_rdata,         // Read data, next cycle
    output wire            irq                // Level interrupt
);
    wire                    stuck0;           // Input 0 failure pulse
    wire                    stuck1;           // Input 1 failure pulse
    wire                    clr_evt;          // Alarm clear event
    reg                     sel_q;            // Last sampled select level
    reg                     init_done;        // Indicator seeded from select
    reg  [CW-1:0]           window;           // Stuck window in cycles
    reg  [`RRCF_IRQ_W-1:0]  irq_stat;         // Sticky events
    reg  [`RRCF_IRQ_W-1:0]  irq_mask;         // Interrupt enables
    reg                     next_ind;         // Next reference choice
    reg                     auto_sw;          // Auto switch this cycle
    wire                    fail0;            // Input 0 has alarm
    wire                    fail1;            // Input 1 has alarm
    wire                    prim_fail;        // Primary alarm
    wire                    sec_fail;         // Secondary alarm
    wire [`RRCF_IRQ_W-1:0]  evt;              // Event vector
    wire                    wr_irq;           // Write to interrupt status
    localparam [31:0]       WIN_RST = `RRCF_WINDOW_CYC; // Window reset, cut to CW below

    // Monitors for both inputs
    rrcf_stuck_mon #(.CW(CW)) u_mon0 (
        .clk    (clk),
        .srst   (srst),
        .ref_in (ref_input_zero),
        .window (window),
        .stuck  (stuck0)
    );
    rrcf_stuck_mon #(.CW(CW)) u_mon1 (
        .clk    (clk),
        .srst   (srst),
        .ref_in (ref_input_one),
        .window (window),
        .stuck  (stuck1)
    );
    rrcf_edge_sync u_clr (
        .clk   (clk),
        .srst  (srst),
        .pin_n (fail_flag_clear_n),
        .fall  (clr_evt)
    );

    assign fail0              = ~fail_flag_0_n;
    assign fail1              = ~fail_flag_1_n;
    assign auto_failover_mode = manual_auto_n;
    assign prim_fail          = primary_select ? fail1 : fail0;
    assign sec_fail           = primary_select ? fail0 : fail1;

    // Exactly one input feeds the loop
    assign ref_clk_out = active_ref_indicator ? ref_input_one : ref_input_zero;

    // Alarm latches; new failure beats a clear in the same cycle
    always @(posedge clk)
    begin
        if (srst)
        begin
            fail_flag_0_n <= 1'b1;
            fail_flag_1_n <= 1'b1;
        end
        else
        begin
            if (stuck0)
                fail_flag_0_n <= 1'b0;
            else if (clr_evt)
                fail_flag_0_n <= 1'b1;
            if (stuck1)
                fail_flag_1_n <= 1'b0;
            else if (clr_evt)
                fail_flag_1_n <= 1'b1;
        end
    end

    // Reference choice
    always @*
    begin
        next_ind = active_ref_indicator;
        auto_sw  = 1'b0;
        if (!init_done)
            next_ind = primary_select;
        else if (clr_evt)
            next_ind = (fail0 & fail1) ? 1'b0 : primary_select;
        else if (primary_select != sel_q)
            next_ind = primary_select;
        else if (manual_auto_n && prim_fail && !sec_fail
                 && active_ref_indicator == primary_select)
        begin
            next_ind = ~primary_select;
            auto_sw  = 1'b1;
        end
        else if (!manual_auto_n)
            next_ind = primary_select;
    end

    // Selection state
    always @(posedge clk)
    begin
        if (srst)
        begin
            active_ref_indicator <= 1'b0;
            sel_q                <= 1'b0;
            init_done            <= 1'b0;
        end
        else
        begin
            init_done            <= 1'b1;
            sel_q                <= primary_select;
            active_ref_indicator <= next_ind;
        end
    end

    // Output banks: dividers held and banks tri-stated under master reset
    assign divider_reset = output_disable_master_reset;
    assign bank_a_oe     = {NOUT{~output_disable_master_reset}};
    assign bank_b_oe     = {NOUT{~output_disable_master_reset}};
    always @(posedge clk)
    begin
        if (srst || output_disable_master_reset)
        begin
            bank_a_outputs <= {NOUT{1'b0}};
            bank_b_outputs <= {NOUT{1'b0}};
        end
        else
        begin
            bank_a_outputs <= bank_a_drive;
            bank_b_outputs <= bank_b_drive;
        end
    end

    // Interrupt events; set wins over write-one-to-clear
    assign evt    = {auto_sw, stuck1, stuck0};
    assign wr_irq = reg_wr && reg_addr == `RRCF_OFS_IRQ_STAT;
    assign irq    = |(irq_stat & irq_mask);

    // Register writes
    always @(posedge clk)
    begin
        if (srst)
        begin
            irq_stat <= {`RRCF_IRQ_W{1'b0}};
            irq_mask <= `RRCF_MASK_RST;
            window   <= WIN_RST[CW-1:0];
        end
        else
        begin
            irq_stat <= (irq_stat & ~(wr_irq ? reg_wdata[`RRCF_IRQ_W-1:0]
                                             : {`RRCF_IRQ_W{1'b0}})) | evt;
            if (reg_wr && reg_addr == `RRCF_OFS_IRQ_MASK)
                irq_mask <= reg_wdata[`RRCF_IRQ_W-1:0];
            else if (reg_wr && reg_addr == `RRCF_OFS_WINDOW && reg_wdata[CW-1:0] != 0)
                window <= reg_wdata[CW-1:0];
        end
    end

    // Register reads, one cycle latency, unmapped reads zero
    always @(posedge clk)
    begin
        if (srst)
            reg_rdata <= 32'h0;
        else if (!reg_rd)
            reg_rdata <= 32'h0;
        else if (reg_addr == `RRCF_OFS_CTRL)
            reg_rdata <= {28'h0, output_disable_master_reset, manual_auto_n,
                          primary_select, fail_flag_clear_n};
        else if (reg_addr == `RRCF_OFS_STATUS)
            reg_rdata <= {29'h0, active_ref_indicator, fail1, fail0};
        else if (reg_addr == `RRCF_OFS_IRQ_STAT)
            reg_rdata <= {29'h0, irq_stat};
        else if (reg_addr == `RRCF_OFS_IRQ_MASK)
            reg_rdata <= {29'h0, irq_mask};
        else if (reg_addr == `RRCF_OFS_WINDOW)
            reg_rdata <= {{(32-CW){1'b0}}, window};
        else
            reg_rdata <= 32'h0;
    end
endmodule // rrcf_top

// File: tb/rrcf_ref_src.sv
// Purpose: Two board reference sources
// Assumes: Period of four core cycles
// Notes:   A stop input freezes a source at its last level
`timescale 1ns/10ps
module rrcf_ref_src (
    input  wire clk,                          // Core clock
    input  wire stop0,                        // Freeze source 0
    input  wire stop1,                        // Freeze source 1
    output reg  ref0,                         // Source 0
    output reg  ref1                          // Source 1
);
    reg ph;                                   // Phase toggle
    initial
    begin
        ph = 1'b0;
        ref0 = 1'b0;
        ref1 = 1'b1;
    end
    // Sources toggle on alternate cycles, offset by one
    always @(posedge clk)
    begin
        ph <= ~ph;
        if (!stop0 && ph) ref0 <= ~ref0;
        if (!stop1 && !ph) ref1 <= ~ref1;
    end
endmodule // rrcf_ref_src

// File: tb/rrcf_sva.sv
// Purpose: Port-level checks on failover control
// Assumes: Window left at its reset value of 9
// Notes:   Bound to rrcf_top
`timescale 1ns/10ps
module rrcf_sva #(
    parameter NOUT = 6                        // Outputs per bank
) (
    input wire            clk, srst, ref_input_zero, ref_input_one,
    input wire            primary_select, manual_auto_n, fail_flag_clear_n,
    input wire            output_disable_master_reset, ref_clk_out,
    input wire            active_ref_indicator, fail_flag_0_n, fail_flag_1_n,
    input wire            auto_failover_mode, divider_reset,
    input wire [NOUT-1:0] bank_a_outputs, bank_a_oe, bank_b_oe
);
    reg       p0, p1;                         // Last samples
    reg [4:0] st0, st1;                       // Unchanged-sample counts
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Count samples without a level change
    always @(posedge clk)
    begin
        p0 <= ref_input_zero;
        p1 <= ref_input_one;
        st0 <= (srst || ref_input_zero != p0) ? 5'h0 : st0 + {4'h0, st0 != 5'h1f};
        st1 <= (srst || ref_input_one != p1) ? 5'h0 : st1 + {4'h0, st1 != 5'h1f};
    end
    chk_ref_mux: assert property (ref_clk_out == (active_ref_indicator ?
        ref_input_one : ref_input_zero)) else $error("reference mux wrong");
    chk_manual_follow: assert property (!manual_auto_n && (fail_flag_0_n ||
        fail_flag_1_n) |=> active_ref_indicator == $past(primary_select))
        else $error("indicator not following select");
    chk_stuck_zero: assert property (st0 >= 5'd12 |-> !fail_flag_0_n)
        else $error("stuck input 0 not flagged");
    chk_stuck_one: assert property (st1 >= 5'd12 |-> !fail_flag_1_n)
        else $error("stuck input 1 not flagged");
    chk_no_false: assert property ($fell(fail_flag_0_n) |-> $past(st0) >= 5'd7)
        else $error("alarm 0 without stuck input");
    chk_alarm_hold: assert property ($rose(fail_flag_0_n) || $rose(fail_flag_1_n)
        |-> !$past(fail_flag_clear_n, 2) || !$past(fail_flag_clear_n, 4))
        else $error("alarm released without clear");
    chk_auto_switch: assert property (manual_auto_n && !primary_select &&
        !active_ref_indicator && $fell(fail_flag_0_n) && fail_flag_1_n
        |=> active_ref_indicator) else $error("no automatic switch");
    chk_mode_pin: assert property (auto_failover_mode == manual_auto_n)
        else $error("mode output wrong");
    chk_out_enable: assert property (bank_a_oe == {NOUT{!output_disable_master_reset}}
        && bank_b_oe == bank_a_oe && divider_reset == output_disable_master_reset)
        else $error("enables or divider reset wrong");
    chk_bank_zero: assert property (output_disable_master_reset |=> bank_a_outputs == 0)
        else $error("bank data not held");
endmodule // rrcf_sva
bind rrcf_top rrcf_sva #(.NOUT(NOUT)) u_sva (.clk(clk), .srst(srst),
    .ref_input_zero(ref_input_zero), .ref_input_one(ref_input_one),
    .primary_select(primary_select), .manual_auto_n(manual_auto_n),
    .fail_flag_clear_n(fail_flag_clear_n), .ref_clk_out(ref_clk_out),
    .output_disable_master_reset(output_disable_master_reset),
    .active_ref_indicator(active_ref_indicator), .fail_flag_0_n(fail_flag_0_n),
    .fail_flag_1_n(fail_flag_1_n), .auto_failover_mode(auto_failover_mode),
    .divider_reset(divider_reset), .bank_a_outputs(bank_a_outputs),
    .bank_a_oe(bank_a_oe), .bank_b_oe(bank_b_oe));

// File: tb/rrcf_top_tb.sv
// Purpose: Bench for reference failover control
// Assumes: Window at 9 cycles, sources run at 31.25 MHz
// Notes:   Sequences of register and pin operations
`timescale 1ns/10ps
`include "rrcf_defs.vh"
module rrcf_top_tb;
    reg        clk, srst, sel, man_n, clr_n, mr, wr, rd, stop0, stop1;
    reg  [5:0] da, db;                        // Bank source levels
    reg  [7:0] addr;                          // Register address
    reg [31:0] wd;                            // Write data
    wire[31:0] rdat;                          // Read data
    wire       r0, r1, ind, f0, f1, dr, irq;  // Source and design outputs
    wire [5:0] qa, qb, oa, ob;                // Bank data and enables
    integer    n_fail, checked;               // Counters
    rrcf_ref_src src (.clk(clk), .stop0(stop0), .stop1(stop1), .ref0(r0), .ref1(r1));
    rrcf_top dut (.clk(clk), .srst(srst), .ref_input_zero(r0), .ref_input_one(r1),
        .primary_select(sel), .manual_auto_n(man_n), .fail_flag_clear_n(clr_n),
        .output_disable_master_reset(mr), .bank_a_drive(da), .bank_b_drive(db),
        .ref_clk_out(), .active_ref_indicator(ind), .fail_flag_0_n(f0),
        .fail_flag_1_n(f1), .auto_failover_mode(), .divider_reset(dr),
        .bank_a_outputs(qa), .bank_a_oe(oa), .bank_b_outputs(qb), .bank_b_oe(ob),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .irq(irq));
    // Free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Compare and count
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("BAD %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Cycles, then settle
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // One-cycle register write
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            wr <= 1'b1;
            addr <= a;
            wd <= d;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    // One-cycle read, data compared in the following cycle
    task rd_reg(input [7:0] a, input [31:0] exp, input string nm);
        begin
            @(posedge clk);
            rd <= 1'b1;
            addr <= a;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            chk(nm, rdat, exp);
        end
    endtask
    // Falling edge on the clear pin
    task clr_pulse;
        begin
            clr_n <= 1'b0;
            cyc(8);
            clr_n <= 1'b1;
            cyc(4);
        end
    endtask
    // Counts and verdict
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail = n_fail + 1;
        complete_run;
    end
    // Main sequence; power-up in manual with outputs disabled
    initial
    begin
        {srst, mr, clr_n} = 3'h7;
        {sel, man_n, wr, rd, stop0, stop1} = 6'h0;
        {da, db, addr, wd} = 52'h0;
        n_fail = 0;
        checked = 0;
        cyc(6);
        srst <= 1'b0;
        rd_reg(`RRCF_OFS_CTRL, 32'h9, "ctrl");
        chk("oe off", {oa, ob, qa}, 32'h0);
        mr <= 1'b0;
        cyc(2);
        chk("oe on", {oa, ob, dr}, 32'h1ffe);
        clr_pulse;
        rd_reg(`RRCF_OFS_STATUS, 32'h0, "start");
        rd_reg(`RRCF_OFS_WINDOW, 32'h9, "window");
        wr_reg(`RRCF_OFS_WINDOW, 32'h0);
        rd_reg(`RRCF_OFS_WINDOW, 32'h9, "window zero");
        rd_reg(`RRCF_OFS_IRQ_MASK, 32'h0, "mask");
        rd_reg(8'h14, 32'h0, "unmapped");
        $display("test start done");
        sel <= 1'b1;
        cyc(3);
        rd_reg(`RRCF_OFS_STATUS, 32'h4, "sel one");
        stop1 <= 1'b1;
        cyc(20);
        rd_reg(`RRCF_OFS_STATUS, 32'h6, "manual fail");
        rd_reg(`RRCF_OFS_IRQ_STAT, 32'h2, "stat");
        chk("irq masked", irq, 32'h0);
        wr_reg(`RRCF_OFS_IRQ_MASK, 32'h2);
        cyc(1);
        chk("irq", irq, 32'h1);
        stop1 <= 1'b0;
        cyc(3);
        wr_reg(`RRCF_OFS_IRQ_STAT, 32'h2);
        cyc(1);
        chk("irq cleared", irq, 32'h0);
        rd_reg(`RRCF_OFS_STATUS, 32'h6, "held");
        clr_pulse;
        rd_reg(`RRCF_OFS_STATUS, 32'h4, "cleared");
        sel <= 1'b0;
        cyc(3);
        rd_reg(`RRCF_OFS_STATUS, 32'h0, "sel zero");
        $display("test manual done");
        man_n <= 1'b1;
        stop0 <= 1'b1;
        cyc(20);
        rd_reg(`RRCF_OFS_STATUS, 32'h5, "auto switch");
        rd_reg(`RRCF_OFS_IRQ_STAT, 32'h5, "switch stat");
        stop0 <= 1'b0;
        cyc(3);
        clr_pulse;
        rd_reg(`RRCF_OFS_STATUS, 32'h0, "reselect");
        wr_reg(`RRCF_OFS_IRQ_STAT, 32'h5);
        rd_reg(`RRCF_OFS_IRQ_STAT, 32'h0, "w1c");
        sel <= 1'b1;
        cyc(3);
        rd_reg(`RRCF_OFS_STATUS, 32'h4, "auto sel");
        stop0 <= 1'b1;
        cyc(20);
        stop1 <= 1'b1;
        cyc(20);
        rd_reg(`RRCF_OFS_STATUS, 32'h7, "no switch");
        {stop0, stop1} <= 2'h0;
        cyc(3);
        clr_pulse;
        rd_reg(`RRCF_OFS_STATUS, 32'h0, "both clear");
        $display("test auto done");
        // Second power-up, straight into automatic mode
        {srst, mr, man_n, sel} <= 4'hf;
        cyc(6);
        srst <= 1'b0;
        cyc(2);
        rd_reg(`RRCF_OFS_STATUS, 32'h4, "auto start");
        clr_pulse;
        rd_reg(`RRCF_OFS_STATUS, 32'h4, "auto ready");
        mr <= 1'b0;
        $display("test auto start done");
        {da, db} <= 12'hab5;
        cyc(3);
        chk("banks", {qa, qb}, 32'hab5);
        mr <= 1'b1;
        cyc(2);
        chk("banks off", {qa, qb, oa, ob, dr}, 32'h1);
        $display("test reset done");
        complete_run;
    end
endmodule // rrcf_top_tb
